// ===== shared/txbs_defines.vh
`ifndef TXBS_DEFINES_VH
`define TXBS_DEFINES_VH
// command word a fields
`define TXBS_CA_FS_BIT        13
`define TXBS_CA_LS_BIT        12
`define TXBS_CA_END_ALN_MSB   25
`define TXBS_CA_END_ALN_LSB   24
`define TXBS_CA_OFS_MSB       20
`define TXBS_CA_OFS_LSB       16
`define TXBS_CA_SIZE_MSB      10
// command word b fields
`define TXBS_CB_TAG_MSB       31
`define TXBS_CB_TAG_LSB       16
`define TXBS_CB_LEN_MSB       10
// status word fields
`define TXBS_ST_ES_BIT        15
`define TXBS_ST_LOC_BIT       11
`define TXBS_ST_NOC_BIT       10
`define TXBS_ST_LATE_BIT      9
`define TXBS_ST_EXC_BIT       8
`define TXBS_ST_CCNT_MSB      6
`define TXBS_ST_CCNT_LSB      3
`define TXBS_ST_EDEF_BIT      2
`define TXBS_ST_DEF_BIT       0
// limits
`define TXBS_MIL_LIMIT_BYTES  2036
`define TXBS_MAX_OVERHEAD     6
`define TXBS_MAX_FRAGS        86
`define TXBS_MID_MIN_BYTES    4
`define TXBS_DEFER_BIT_TIMES  24288
`define TXBS_MAX_COLLISIONS   16
// reset values
`define TXBS_RST_WORD         32'h00000000
`define TXBS_RST_COUNT        5'h00
`endif

// ===== src/txbs_top.v
`timescale 1ns/1ps
`include "txbs_defines.vh"

// Notes on behaviour
// - mac fifo gets only payload bytes
// - per buffer overhead at most six bytes
// - one status word per sent packet
// - full status fifo suspends transmission
// - discard enable keeps transmitter running when full
// - discarded overrun holds used count zero, no writes
// - no error flag on discarded overrun
// - status high half returns packet tag
// - bit fifteen ORs all error bits
// - carrier loss bit11, no carrier bit10
// - late collision sets bit nine
// - sixteen collisions set bit eight
// - collision count in bits six to three
// - excessive deferral sets bit two
// - deferred packet sets bit zero
// - command a always, b on first segment
// - whole start offset words dropped
// - whole end padding words dropped
module txbs_top #(
  parameter STAT_DEPTH_LOG2 = 4
) (
  clk,
  rst,
  in_valid,
  in_data,
  in_ready,
  dfifo_valid,
  dfifo_data,
  mil_valid,
  mil_data,
  mil_be,
  tx_done,
  tx_carrier_lost,
  tx_no_carrier,
  tx_late_coll,
  tx_excess_coll,
  tx_coll_count,
  tx_excess_defer,
  tx_deferred,
  tx_hold,
  status_discard_overrun_enable,
  stat_rd,
  stat_valid,
  stat_data,
  status_fifo_used_count,
  transmit_error_flag
);
  input  wire                       clk;
  input  wire                       rst;
  input  wire                       in_valid;   // host word written
  input  wire [31:0]                in_data;
  output reg                        in_ready;
  output reg                        dfifo_valid; // word entering tx data fifo
  output reg  [31:0]                dfifo_data;
  output reg                        mil_valid;   // word entering mac fifo
  output reg  [31:0]                mil_data;
  output reg  [3:0]                 mil_be;
  input  wire                       tx_done;     // mac finished one packet
  input  wire                       tx_carrier_lost;
  input  wire                       tx_no_carrier;
  input  wire                       tx_late_coll;
  input  wire                       tx_excess_coll;
  input  wire [3:0]                 tx_coll_count;
  input  wire                       tx_excess_defer;
  input  wire                       tx_deferred;
  output reg                        tx_hold;     // suspend mac transmission
  input  wire                       status_discard_overrun_enable;
  input  wire                       stat_rd;
  output reg                        stat_valid;
  output reg  [31:0]                stat_data;
  output reg  [STAT_DEPTH_LOG2:0]   status_fifo_used_count;
  output reg                        transmit_error_flag;

  localparam DEPTH = 1 << STAT_DEPTH_LOG2;
  localparam [STAT_DEPTH_LOG2:0] FULL_CNT = {1'b1, {STAT_DEPTH_LOG2{1'b0}}};

  // buffer parser states
  localparam [2:0] ST_CMDA = 3'h0;
  localparam [2:0] ST_CMDB = 3'h1;
  localparam [2:0] ST_OFS  = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_PAD  = 3'h4;

  reg [2:0]  state_q;
  reg        first_q;
  reg        last_q;
  reg [2:0]  skip_q;       // whole words still to drop
  reg [1:0]  lead_q;       // byte offset inside first data word
  reg [12:0] remain_q;     // payload bytes plus lead still to pass
  reg [6:0]  pad_words_q;  // end alignment words still to drop

  ////////////////////////////////////////////////////////////////////////
  // packet tag queue: the host may hand over later packets before the mac
  // reports the earlier one done, so each tag waits here in packet order
  reg [15:0]                tag_mem_q [0:DEPTH-1];
  reg [STAT_DEPTH_LOG2-1:0] tag_wr_q;
  reg [STAT_DEPTH_LOG2-1:0] tag_rd_q;
  reg [STAT_DEPTH_LOG2:0]   tag_cnt_q;

  wire        tag_full  = (tag_cnt_q == FULL_CNT);
  wire        tag_empty = (tag_cnt_q == {(STAT_DEPTH_LOG2+1){1'b0}});
  // queued when the second command word of a first segment is taken
  wire        tag_push  = in_valid && in_ready && (state_q == ST_CMDB) && first_q && !tag_full;
  // every finished packet retires its tag, also when its status is dropped
  wire        tag_pop   = tx_done && !tag_empty;
  // a done report with no packet queued carries a zero tag
  wire [15:0] tag_head  = tag_empty ? 16'h0000 : tag_mem_q[tag_rd_q];

  // tag storage, flops only
  always @(posedge clk) begin
    if (tag_push) begin
      tag_mem_q[tag_wr_q] <= in_data[`TXBS_CB_TAG_MSB:`TXBS_CB_TAG_LSB];
    end
  end

  // tag pointers; a full queue drops further tags rather than wrap
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tag_wr_q  <= {STAT_DEPTH_LOG2{1'b0}};
      tag_rd_q  <= {STAT_DEPTH_LOG2{1'b0}};
      tag_cnt_q <= {(STAT_DEPTH_LOG2+1){1'b0}};
    end else begin
      if (tag_push) begin
        tag_wr_q <= tag_wr_q + 1'b1;
      end
      if (tag_pop) begin
        tag_rd_q <= tag_rd_q + 1'b1;
      end
      if (tag_push && !tag_pop) begin
        tag_cnt_q <= tag_cnt_q + 1'b1;
      end else if (tag_pop && !tag_push) begin
        tag_cnt_q <= tag_cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status fifo storage and pointers
  reg [31:0]                mem_q [0:DEPTH-1];
  reg [STAT_DEPTH_LOG2-1:0] wr_ptr_q;
  reg [STAT_DEPTH_LOG2-1:0] rd_ptr_q;
  reg [STAT_DEPTH_LOG2:0]   cnt_q;
  reg                       ovr_q;  // discard overrun seen, held until a read

  wire full = (cnt_q == FULL_CNT);
  wire do_rd = stat_rd && (cnt_q != {(STAT_DEPTH_LOG2+1){1'b0}});
  // writes are blocked while full or while an overrun waits for a read
  wire do_wr = tx_done && !full && !ovr_q;
  wire ovr_ev = tx_done && full && status_discard_overrun_enable;

  // error summary from this packet's error inputs
  wire es = tx_carrier_lost | tx_no_carrier | tx_late_coll | tx_excess_coll | tx_excess_defer;

  // status word assembly, reserved bits 14:12, 7 and 1 stay zero
  wire [31:0] st_word = {tag_head,
                         es,
                         3'b000,
                         tx_carrier_lost,
                         tx_no_carrier,
                         tx_late_coll,
                         tx_excess_coll,
                         1'b0,
                         tx_coll_count,
                         tx_excess_defer,
                         1'b0,
                         tx_deferred};

  // storage write, flops only
  always @(posedge clk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= st_word;
    end
  end

  // pointer and counter update; overrun clears only once space is freed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= {STAT_DEPTH_LOG2{1'b0}};
      rd_ptr_q <= {STAT_DEPTH_LOG2{1'b0}};
      cnt_q    <= {(STAT_DEPTH_LOG2+1){1'b0}};
      ovr_q    <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (ovr_ev) begin
        ovr_q <= 1'b1;
      end else if (do_rd) begin
        ovr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status side outputs, all registered
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_valid             <= 1'b0;
      stat_data              <= `TXBS_RST_WORD;
      status_fifo_used_count <= {(STAT_DEPTH_LOG2+1){1'b0}};
      tx_hold                <= 1'b0;
      transmit_error_flag    <= 1'b0;
    end else begin
      stat_valid <= (cnt_q != {(STAT_DEPTH_LOG2+1){1'b0}});
      stat_data  <= mem_q[rd_ptr_q];
      // while an overrun is pending the used count reads zero
      status_fifo_used_count <= (ovr_q || ovr_ev) ? {(STAT_DEPTH_LOG2+1){1'b0}} : cnt_q;
      // suspend while full unless discard overrun is allowed
      tx_hold <= full && !do_rd && !status_discard_overrun_enable;
      // sticky error flag, cleared only by reset in this block
      if (tx_done && full && !status_discard_overrun_enable) begin
        transmit_error_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer parser: strips whole offset and padding words before the data
  // fifo, and command words before the mac fifo
  wire [1:0]  ofs_lo  = in_data[`TXBS_CA_OFS_LSB+1:`TXBS_CA_OFS_LSB];
  wire [2:0]  ofs_hi  = in_data[`TXBS_CA_OFS_MSB:`TXBS_CA_OFS_LSB+2];
  wire [10:0] bsize   = in_data[`TXBS_CA_SIZE_MSB:0];
  wire [12:0] span    = {2'b00, bsize} + {11'h000, ofs_lo};
  wire [1:0]  aln     = in_data[`TXBS_CA_END_ALN_MSB:`TXBS_CA_END_ALN_LSB];
  // data words the host sends = ceil(span/4); padded to 1, 4 or 8 words
  wire [10:0] dwords  = span[12:2] + {10'h000, |span[1:0]};
  wire [10:0] amask   = (aln == 2'b01) ? 11'h003 : (aln == 2'b10) ? 11'h007 : 11'h000;
  wire [10:0] padw    = (~dwords + 11'h001) & amask;
  wire [12:0] rem_sub = remain_q - 13'h0004;
  wire        is_last = (remain_q <= 13'h0004);
  // nonzero whole-word offset still to skip
  wire        ofs_hi_nz = (skip_q != 3'h0);
  // an empty buffer with no padding goes straight back for the next command
  wire [2:0]  st_after_ofs = (remain_q != 13'h0000) ? ST_DATA : (pad_words_q != 7'h00) ? ST_PAD : ST_CMDA;

  // byte enables for the current data word
  reg [3:0] be_c;
  always @* begin
    be_c = 4'hF;
    if (lead_q != 2'b00) begin
      be_c = 4'hF << lead_q;
    end
    if (is_last && remain_q[1:0] != 2'b00) begin
      be_c = be_c & ~(4'hF << remain_q[1:0]);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_CMDA;
      first_q     <= 1'b0;
      last_q      <= 1'b0;
      skip_q      <= 3'h0;
      lead_q      <= 2'b00;
      remain_q    <= 13'h0000;
      pad_words_q <= 7'h00;
      in_ready    <= 1'b0;
      dfifo_valid <= 1'b0;
      dfifo_data  <= `TXBS_RST_WORD;
      mil_valid   <= 1'b0;
      mil_data    <= `TXBS_RST_WORD;
      mil_be      <= 4'h0;
    end else begin
      in_ready    <= 1'b1;
      dfifo_valid <= 1'b0;
      mil_valid   <= 1'b0;
      if (in_valid && in_ready) begin
        case (state_q)
          ST_CMDA: begin
            dfifo_valid <= 1'b1;
            dfifo_data  <= in_data;
            first_q     <= in_data[`TXBS_CA_FS_BIT];
            last_q      <= in_data[`TXBS_CA_LS_BIT];
            skip_q      <= ofs_hi;
            lead_q      <= ofs_lo;
            remain_q    <= span;
            pad_words_q <= padw[6:0];
            state_q     <= ST_CMDB;
          end
          ST_CMDB: begin
            // second command word reaches the data fifo on a first segment only
            if (first_q) begin
              dfifo_valid <= 1'b1;
              dfifo_data  <= in_data;
            end
            state_q <= ofs_hi_nz ? ST_OFS : st_after_ofs;
          end
          ST_OFS: begin
            // whole offset words are consumed and dropped
            skip_q <= skip_q - 3'h1;
            if (skip_q == 3'h1) begin
              state_q <= st_after_ofs;
            end
          end
          ST_DATA: begin
            // partial leading/trailing bytes ride along; mac sees only enabled lanes
            dfifo_valid <= 1'b1;
            dfifo_data  <= in_data;
            mil_valid   <= (be_c != 4'h0);
            mil_data    <= in_data;
            mil_be      <= be_c;
            lead_q      <= 2'b00;
            remain_q    <= is_last ? 13'h0000 : rem_sub;
            if (is_last) begin
              state_q <= (pad_words_q != 7'h00) ? ST_PAD : ST_CMDA;
            end
          end
          ST_PAD: begin
            // whole padding words are dropped
            pad_words_q <= pad_words_q - 7'h01;
            if (pad_words_q <= 7'h01) begin
              state_q <= ST_CMDA;
            end
          end
          default: begin
            state_q <= ST_CMDA;
          end
        endcase
      end
    end
  end

endmodule

// ===== bench/txbs_chk.sv
`timescale 1ns/1ps
// windows of one to three cycles cover the registered status path
module txbs_chk #(
  parameter STAT_DEPTH_LOG2 = 4
) (
  input wire                       clk,
  input wire                       rst,
  input wire                       in_valid,
  input wire                       in_ready,
  input wire                       dfifo_valid,
  input wire                       mil_valid,
  input wire [3:0]                 mil_be,
  input wire                       tx_done,
  input wire                       tx_hold,
  input wire                       status_discard_overrun_enable,
  input wire                       stat_rd,
  input wire                       stat_valid,
  input wire [31:0]                stat_data,
  input wire [STAT_DEPTH_LOG2:0]   status_fifo_used_count,
  input wire                       transmit_error_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire full = status_fifo_used_count == (1 << STAT_DEPTH_LOG2);
  wire disc = status_discard_overrun_enable;
  ////////////////////////////////////////
  // a packet finishing into a full status store, and a pop that frees it
  sequence s_done_full(d);
    tx_done && full && disc == d;
  endsequence
  sequence s_pop_full;
    stat_rd && full && !disc;
  endsequence
  AST_ES: assert property (stat_valid |-> stat_data[15] == |{stat_data[11:8], stat_data[2:1]})
    else $error("error summary wrong");
  AST_RSVD: assert property (stat_valid |-> stat_data[14:12] == 3'h0 && !stat_data[7] && !stat_data[1])
    else $error("reserved status bits set");
  AST_MIL: assert property (mil_valid |-> dfifo_valid && mil_be != 4'h0)
    else $error("mac fifo word without payload");
  AST_DF_CAUSE: assert property (dfifo_valid |-> $past(in_valid && in_ready))
    else $error("data fifo word without host word");
  AST_HOLD: assert property (tx_hold |-> !disc && (full || $past(full)))
    else $error("hold without full store");
  AST_RESUME: assert property (s_pop_full |-> ##[1:3] !tx_hold)
    else $error("no resume after pop");
  AST_OVR_ERR: assert property (s_done_full(1'b0) |-> ##[1:2] transmit_error_flag)
    else $error("overrun not flagged");
  AST_NO_ERR: assert property (s_done_full(1'b1) ##0 !transmit_error_flag |=> !transmit_error_flag [*3])
    else $error("discarded overrun flagged");
  AST_ZERO: assert property (s_done_full(1'b1) |-> ##[1:2] status_fifo_used_count == 0)
    else $error("used count not zero on overrun");
  AST_ONE: assert property (tx_done && !full && !stat_rd |-> ##[1:2] stat_valid)
    else $error("status word missing");
  AST_RUN: assert property (disc |-> !tx_hold)
    else $error("hold while discard enabled");
endmodule

bind txbs_top txbs_chk #(.STAT_DEPTH_LOG2(STAT_DEPTH_LOG2)) i_chk (
  .clk(clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready), .dfifo_valid(dfifo_valid),
  .mil_valid(mil_valid), .mil_be(mil_be), .tx_done(tx_done), .tx_hold(tx_hold),
  .status_discard_overrun_enable(status_discard_overrun_enable), .stat_rd(stat_rd),
  .stat_valid(stat_valid), .stat_data(stat_data), .status_fifo_used_count(status_fifo_used_count),
  .transmit_error_flag(transmit_error_flag)
);

// ===== bench/txbs_host.sv
`timescale 1ns/1ps
module txbs_host (
  input  wire         clk,
  input  wire         in_ready,
  output logic        in_valid,
  output logic [31:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data  = 32'h0;
  end
  ////////////////////////////////////////
  // returns on the taking edge so words chain back to back
  task put(input logic [31:0] w);
    #1;
    in_valid = 1'b1;
    in_data  = w;
    @(posedge clk);
    for (int n = 0; n < 100 && !in_ready; n++) @(posedge clk);
  endtask
  // any byte alignment and length; callers keep middles at four bytes or more
  task send_buf(input logic [31:0] a, input logic [31:0] b);
    int o, n, w, pad;
    o   = a[20:16];
    n   = (a[10:0] + a[17:16] + 3) / 4;
    w   = (a[25:24] == 2'h0) ? 1 : (a[25:24] == 2'h1) ? 4 : 8;
    pad = (w - n % w) % w; // end alignment counts data words only
    put(a);
    put(b);
    for (int i = 0; i < o / 4; i++) put(32'hFFFFFFFF);
    for (int i = 0; i < n; i++) put({b[23:16], 8'hC0, 8'h00, i[7:0]});
    for (int i = 0; i < pad; i++) put(32'h00000000);
    #1;
    in_valid = 1'b0;
    in_data  = ~in_data; // a stale word must not look valid
    @(posedge clk);
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk, rst, in_valid, in_ready, dfifo_valid, mil_valid, tx_done, tx_hold, stat_rd, stat_valid;
  logic        tx_carrier_lost, tx_no_carrier, tx_late_coll, tx_excess_coll, tx_excess_defer, tx_deferred;
  logic        status_discard_overrun_enable, transmit_error_flag;
  logic [31:0] in_data, dfifo_data, mil_data, stat_data;
  logic [3:0]  mil_be, tx_coll_count;
  logic [4:0]  status_fifo_used_count;
  logic [35:0] q[$];
  logic [35:0] e;
  logic [9:0]  ev;
  int          bad_count, samples_checked;

  txbs_top #(.STAT_DEPTH_LOG2(4)) i_txbs_top (.clk(clk), .rst(rst), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .dfifo_valid(dfifo_valid), .dfifo_data(dfifo_data), .mil_valid(mil_valid),
    .mil_data(mil_data), .mil_be(mil_be), .tx_done(tx_done), .tx_carrier_lost(tx_carrier_lost),
    .tx_no_carrier(tx_no_carrier), .tx_late_coll(tx_late_coll), .tx_excess_coll(tx_excess_coll),
    .tx_coll_count(tx_coll_count), .tx_excess_defer(tx_excess_defer), .tx_deferred(tx_deferred),
    .tx_hold(tx_hold), .status_discard_overrun_enable(status_discard_overrun_enable), .stat_rd(stat_rd),
    .stat_valid(stat_valid), .stat_data(stat_data), .status_fifo_used_count(status_fifo_used_count),
    .transmit_error_flag(transmit_error_flag));
  txbs_host host (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));

  always #4 clk = ~clk;
  ////////////////////////////////////////
  task end_of_test;
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp_w(input logic [35:0] g, input logic [35:0] x);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task cmp_b(input logic g, input logic x);
    cmp_w({35'h0, g}, {35'h0, x});
  endtask
  function automatic logic [31:0] ca(input logic [1:0] al, input logic [4:0] o, input logic f, input logic l,
                                     input logic [10:0] s);
    return {6'h00, al, 3'h0, o, 2'h0, f, l, 1'b0, s};
  endfunction
  // bits of ev: lost, none, late, excess, deferral, deferred, count
  function automatic logic [31:0] sw(input logic [15:0] t, input logic [9:0] x);
    return {t, |x[9:5], 3'h0, x[9:6], 1'b0, x[3:0], x[5], 1'b0, x[4]};
  endfunction
  // commands, then payload words with their byte lanes; be of zero marks a command
  task pkt(input logic [31:0] a, input logic [31:0] b);
    int o, s, n;
    logic [3:0] be;
    o = a[17:16];
    s = a[10:0];
    n = (s + o + 3) / 4;
    q.push_back({4'h0, a});
    if (a[13]) q.push_back({4'h0, b});
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 4; j++) be[j] = (4 * k + j >= o) && (4 * k + j < o + s);
      q.push_back({be, b[23:16], 8'hC0, 8'h00, k[7:0]});
    end
    host.send_buf(a, b);
  endtask
  task done(input logic [9:0] x);
    #1;
    {tx_carrier_lost, tx_no_carrier, tx_late_coll, tx_excess_coll, tx_excess_defer, tx_deferred, tx_coll_count} = x;
    tx_done = 1'b1;
    @(posedge clk);
    #1;
    tx_done = 1'b0;
    @(posedge clk);
  endtask
  task rd_stat(input logic [31:0] x);
    repeat (2) @(posedge clk);
    #1;
    cmp_b(stat_valid, 1'b1);
    cmp_w({4'h0, stat_data}, {4'h0, x});
    stat_rd = 1'b1;
    @(posedge clk);
    #1;
    stat_rd = 1'b0;
    @(posedge clk);
  endtask
  task chk_st(input logic h, input logic f, input logic [4:0] u);
    repeat (2) @(posedge clk);
    #1;
    cmp_b(tx_hold, h);
    cmp_b(transmit_error_flag, f);
    cmp_w({31'h0, status_fifo_used_count}, {31'h0, u});
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  // every word entering the data fifo is matched in order
  always @(negedge clk) if (dfifo_valid) begin
    e = q.size() ? q.pop_front() : 36'hFFFFFFFFF;
    cmp_w({mil_valid ? mil_be : 4'h0, dfifo_data}, e);
    if (mil_valid) cmp_w({mil_be, mil_data}, e);
  end
  // generous bound: the sequence needs about five hundred cycles
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {clk, rst, tx_done, stat_rd, status_discard_overrun_enable} = 5'h08;
    {tx_carrier_lost, tx_no_carrier, tx_late_coll, tx_excess_coll, tx_excess_defer, tx_deferred} = 6'h00;
    tx_coll_count = 4'h0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    pkt(ca(2'h0, 5'h02, 1'b1, 1'b1, 11'h0B7), {16'h0001, 5'h00, 11'h0B7});
    pkt(ca(2'h1, 5'h07, 1'b1, 1'b0, 11'h04F), {16'h0002, 5'h00, 11'h06F});
    pkt(ca(2'h1, 5'h00, 1'b0, 1'b0, 11'h00F), {16'h0002, 5'h00, 11'h06F});
    pkt(ca(2'h1, 5'h0A, 1'b0, 1'b1, 11'h011), {16'h0002, 5'h00, 11'h06F});
    done(10'h000);
    rd_stat(sw(16'h0001, 10'h000));
    done(10'h005);
    rd_stat(sw(16'h0002, 10'h005));
    for (int i = 0; i < 8; i++) begin
      pkt(ca(2'h0, i[4:0], 1'b1, 1'b1, 11'h001 + i[10:0]), {16'h0100 + i[15:0], 5'h00, 11'h001 + i[10:0]});
      ev = (i < 6) ? (10'h200 >> i) : ((i == 6) ? 10'h00F : 10'h013);
      done(ev);
      rd_stat(sw(16'h0100 + i[15:0], ev));
    end
    for (int i = 0; i < 17; i++) begin
      pkt(ca(2'h0, 5'h00, 1'b1, 1'b1, 11'h004), {16'h0200 + i[15:0], 5'h00, 11'h004});
      done(10'h000);
    end
    chk_st(1'b1, 1'b1, 5'h10);
    rd_stat(sw(16'h0200, 10'h000));
    chk_st(1'b0, 1'b1, 5'h0F);
    for (int i = 1; i < 16; i++) rd_stat(sw(16'h0200 + i[15:0], 10'h000));
    #1;
    rst = 1'b1;
    status_discard_overrun_enable = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    for (int i = 0; i < 17; i++) begin
      pkt(ca(2'h0, 5'h00, 1'b1, 1'b1, 11'h004), {16'h0300 + i[15:0], 5'h00, 11'h004});
      done(10'h000);
    end
    chk_st(1'b0, 1'b0, 5'h00);
    rd_stat(sw(16'h0300, 10'h000));
    cmp_b(q.size() == 0, 1'b1);
    end_of_test();
  end
endmodule
